/* File: otp_access_control.v */
// fuse access control registers: page, control, array address and data
// Operation
// - 0xE0-0xFF read-only reserved, reads zero
// - page register at 0x100 mirrors page 0x00
// - id_write_protect makes ten id registers read-only
// - config_fuse_lock blocks fusing of config ranges
// - application_fuse_lock blocks fusing 0x104-0x117
// - general_fuse_lock blocks fusing 0x120-0x134
// - application trigger reloads 0x104-0x117 and lock
// - general trigger reloads 0x120-0x134, protect, lock
// - bit 0 selects normal or marginal fuse read
// - read/write fuse array address at 0x102
// - read/write fuse data at 0x103
// - interface register writable only before app lock
// - base field 0000 means hardware default address
`timescale 1ns/10ps
`include "otp_access_control_defs.vh"
module otp_access_control (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire       wr_en_i,
  input  wire       rd_en_i,
  input  wire [8:0] reg_addr_i,
  input  wire [7:0] wr_data_i,
  output reg  [7:0] rd_data_o,
  output wire [7:0] page_select_o,
  input  wire       emulated_read_active_i,
  output wire       margin_read_o,
  output reg        fuse_rd_req_o,
  output reg  [7:0] fuse_rd_addr_o,
  input  wire       fuse_rd_valid_i,
  input  wire [7:0] fuse_rd_data_i,
  input  wire       fuse_prog_req_i,
  input  wire [8:0] fuse_prog_reg_i,
  output wire       fuse_prog_allow_o,
  output wire       unlock_done_o,
  output reg  [7:0] target_chip_o,
  input  wire [3:0] default_base_i,
  output wire [3:0] if_base_addr_o,
  input  wire       config_lock_fused_i
);
  localparam S_IDLE = 2'h0;
  localparam S_REQ  = 2'h1;
  localparam S_WAIT = 2'h2;
  localparam S_DONE = 2'h3;
  reg [7:0] page_r;
  reg [7:0] ctrl_r;
  reg [7:0] addr_r;
  reg [7:0] data_r;
  reg [7:0] app_mem [0:19];
  reg [7:0] gen_mem [0:20];
  reg [1:0] state_r;
  reg [8:0] rl_idx_r;
  reg       rl_gen_r;
  reg       chip_sel_r;
  reg [1:0] unlock_cnt_r;
  reg       unlocked_r;
  reg       emu_dly_r;
  wire in_app = (reg_addr_i >= `APP_FIRST) && (reg_addr_i <= `APP_LAST);
  wire in_gen = (reg_addr_i >= `GEN_FIRST) && (reg_addr_i <= `GEN_LAST);
  wire is_id  = (reg_addr_i >= `GEN_ID_FIRST) && (reg_addr_i <= `GEN_ID_LAST);
  wire [4:0] app_idx = reg_addr_i[4:0] - 5'h04;
  wire [4:0] gen_idx = reg_addr_i[4:0];
  wire app_wr = wr_en_i && in_app &&
                (reg_addr_i != `APP_INTERFACE || !ctrl_r[`BIT_APP_LOCK]);
  wire gen_wr = wr_en_i && in_gen && !(is_id && ctrl_r[`BIT_ID_WP]);
  wire ctrl_wr = wr_en_i && (reg_addr_i == `FUSE_CONTROL);
  wire [8:0] last_idx = rl_gen_r ? (`GEN_LAST - `GEN_FIRST) : (`APP_LAST - `APP_FIRST);
  wire [8:0] base_reg = rl_gen_r ? `GEN_FIRST : `APP_FIRST;
  wire [8:0] pr = fuse_prog_reg_i;
  wire conf_rng = (pr >= `CONF_A_FIRST && pr <= `CONF_A_LAST) ||
                  (pr >= `CONF_B_FIRST && pr <= `CONF_B_LAST);
  wire app_rng  = pr >= `APP_FIRST && pr <= `APP_LAST;
  wire gen_rng  = pr >= `GEN_FIRST && pr <= `GEN_LAST;
  wire [3:0] fused_base = app_mem[1][7:4];
  assign page_select_o = page_r;
  assign margin_read_o = ctrl_r[`BIT_MARGIN];
  assign unlock_done_o = unlocked_r;
  assign fuse_prog_allow_o = fuse_prog_req_i && unlocked_r &&
                             !(conf_rng && ctrl_r[`BIT_CONF_LOCK]) &&
                             !(app_rng && ctrl_r[`BIT_APP_LOCK]) &&
                             !(gen_rng && ctrl_r[`BIT_GEN_LOCK]);
  assign if_base_addr_o = (fused_base == `BASE_UNPROG) ? default_base_i : fused_base;
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      page_r       <= `PAGE_RESET;
      ctrl_r       <= `CTRL_RESET;
      addr_r       <= `ADDR_RESET;
      data_r       <= `DATA_RESET;
      state_r      <= S_IDLE;
      rl_idx_r     <= 9'h000;
      rl_gen_r     <= 1'b0;
      fuse_rd_req_o  <= 1'b0;
      fuse_rd_addr_o <= 8'h00;
      chip_sel_r   <= 1'b0;
      unlock_cnt_r <= 2'h0;
      unlocked_r   <= 1'b0;
      target_chip_o <= 8'h00;
      emu_dly_r    <= 1'b0;
    end else begin
      emu_dly_r <= emulated_read_active_i;
      ctrl_r[`BIT_CONF_LOCK] <= config_lock_fused_i;
      if (wr_en_i && reg_addr_i == `PAGE_SELECT_HIGH) begin
        page_r <= wr_data_i & `PAGE_RSVD_MASK;
      end
      if (wr_en_i && reg_addr_i == `FUSE_CONTROL) begin
        ctrl_r[`BIT_MARGIN] <= wr_data_i[`BIT_MARGIN];
        if (wr_data_i[`BIT_EMU_DONE]) begin
          ctrl_r[`BIT_EMU_DONE] <= 1'b1;
        end else begin
          ctrl_r[`BIT_EMU_DONE] <= 1'b0;
        end
        if (wr_data_i[`BIT_APP_RELOAD]) ctrl_r[`BIT_APP_RELOAD] <= 1'b1;
        if (wr_data_i[`BIT_GEN_RELOAD]) ctrl_r[`BIT_GEN_RELOAD] <= 1'b1;
      end else if (emu_dly_r && !emulated_read_active_i) begin
        ctrl_r[`BIT_EMU_DONE] <= 1'b0;
      end
      // unlock bookkeeping; a new chip select restarts the sequence
      if (wr_en_i && reg_addr_i == `FUSE_ARRAY_ADDRESS) begin
        addr_r <= wr_data_i;
        if (wr_data_i == data_r) begin
          target_chip_o <= wr_data_i;
          chip_sel_r    <= 1'b1;
          unlock_cnt_r  <= 2'h0;
          unlocked_r    <= 1'b0;
        end
      end
      if (wr_en_i && reg_addr_i == `FUSE_ARRAY_DATA) begin
        data_r <= wr_data_i;
        if (chip_sel_r && !unlocked_r) begin
          if (unlock_cnt_r == `UNLOCK_BYTES) begin
            unlocked_r <= 1'b1;
          end else begin
            unlock_cnt_r <= unlock_cnt_r + 2'h1;
          end
        end
      end
      case (state_r)
        S_IDLE: begin
          if (ctrl_r[`BIT_APP_RELOAD] || ctrl_r[`BIT_GEN_RELOAD]) begin
            rl_gen_r <= !ctrl_r[`BIT_APP_RELOAD];
            rl_idx_r <= 9'h000;
            state_r  <= S_REQ;
          end
        end
        S_REQ: begin
          fuse_rd_req_o  <= 1'b1;
          fuse_rd_addr_o <= base_reg[7:0] + rl_idx_r[7:0];
          state_r        <= S_WAIT;
        end
        S_WAIT: begin
          fuse_rd_req_o <= 1'b0;
          if (fuse_rd_valid_i) begin
            if (rl_idx_r == last_idx) begin
              state_r <= S_DONE;
            end else begin
              rl_idx_r <= rl_idx_r + 9'h001;
              state_r  <= S_REQ;
            end
          end
        end
        default: begin
          // a trigger rewritten in this very cycle wins; one rewritten during S_REQ or S_WAIT is cleared here
          if (rl_gen_r && !(ctrl_wr && wr_data_i[`BIT_GEN_RELOAD])) begin
            ctrl_r[`BIT_GEN_RELOAD] <= 1'b0;
          end else if (!rl_gen_r && !(ctrl_wr && wr_data_i[`BIT_APP_RELOAD])) begin
            ctrl_r[`BIT_APP_RELOAD] <= 1'b0;
          end
          state_r <= S_IDLE;
        end
      endcase
      if (state_r == S_WAIT && fuse_rd_valid_i && rl_idx_r == last_idx) begin
        if (rl_gen_r) begin
          ctrl_r[`BIT_ID_WP]    <= fuse_rd_data_i[`BIT_ID_WP];
          ctrl_r[`BIT_GEN_LOCK] <= fuse_rd_data_i[`BIT_GEN_LOCK];
        end else begin
          ctrl_r[`BIT_APP_LOCK] <= fuse_rd_data_i[`BIT_APP_LOCK];
        end
      end
    end
  end
  // shadow arrays carry no reset; they are filled by reload
  always @(posedge ref_clk_i) begin
    if (state_r == S_WAIT && fuse_rd_valid_i) begin
      if (rl_gen_r) begin
        gen_mem[rl_idx_r[4:0]] <= fuse_rd_data_i;
      end else begin
        app_mem[rl_idx_r[4:0]] <= fuse_rd_data_i;
      end
    end else if (app_wr) begin
      app_mem[app_idx] <= wr_data_i;
    end else if (gen_wr) begin
      gen_mem[gen_idx] <= wr_data_i;
    end
  end
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      if (reg_addr_i >= `CHG_RSVD_FIRST && reg_addr_i <= `CHG_RSVD_LAST) begin
        rd_data_o <= 8'h00;
      end else if (reg_addr_i == `PAGE_SELECT_HIGH) begin
        rd_data_o <= page_r;
      end else if (reg_addr_i == `FUSE_CONTROL) begin
        rd_data_o <= ctrl_r;
      end else if (reg_addr_i == `FUSE_ARRAY_ADDRESS) begin
        rd_data_o <= addr_r;
      end else if (reg_addr_i == `FUSE_ARRAY_DATA) begin
        rd_data_o <= data_r;
      end else if (in_app) begin
        rd_data_o <= app_mem[app_idx];
      end else if (in_gen) begin
        rd_data_o <= gen_mem[gen_idx];
      end else begin
        rd_data_o <= 8'h00;
      end
    end
  end
endmodule

/* File: otp_access_control_defs.vh */
// register offsets, field positions, reset values and the unlock byte count for the fuse access block
`ifndef OTP_ACCESS_CONTROL_DEFS_VH
`define OTP_ACCESS_CONTROL_DEFS_VH
`define CHG_RSVD_FIRST      9'h0E0
`define CHG_RSVD_LAST       9'h0FF
`define PAGE_SELECT_HIGH    9'h100
`define FUSE_CONTROL        9'h101
`define FUSE_ARRAY_ADDRESS  9'h102
`define FUSE_ARRAY_DATA     9'h103
`define APP_FIRST           9'h104
`define APP_LAST            9'h117
`define APP_INTERFACE       9'h105
`define GEN_FIRST           9'h120
`define GEN_LAST            9'h134
`define GEN_ID_FIRST        9'h12B
`define GEN_ID_LAST         9'h134
`define CONF_A_FIRST        9'h00A
`define CONF_A_LAST         9'h036
`define CONF_B_FIRST        9'h082
`define CONF_B_LAST         9'h0CF
`define BIT_ID_WP           7
`define BIT_CONF_LOCK       6
`define BIT_APP_LOCK        5
`define BIT_GEN_LOCK        4
`define BIT_EMU_DONE        3
`define BIT_APP_RELOAD      2
`define BIT_GEN_RELOAD      1
`define BIT_MARGIN          0
`define PAGE_RSVD_MASK      8'hC7
`define PAGE_RESET          8'h00
`define CTRL_RESET          8'h00
`define ADDR_RESET          8'h00
`define DATA_RESET          8'h00
`define UNLOCK_BYTES        2'h3
`define BASE_UNPROG         4'h0
`define FUSE_APP_LOCK_ADDR  8'hF0
`define FUSE_GEN_LOCK_ADDR  8'hF1
`endif

/* File: otp_access_control_checker.sv */
// port assertions for the fuse access block
`timescale 1ns/10ps
module otp_access_control_checker (
  input wire       ref_clk_i,
  input wire       nrst_i,
  input wire       wr_en_i,
  input wire       rd_en_i,
  input wire [8:0] reg_addr_i,
  input wire [7:0] wr_data_i,
  input wire [7:0] rd_data_o,
  input wire [7:0] page_select_o,
  input wire       margin_read_o,
  input wire       fuse_rd_req_o,
  input wire [7:0] fuse_rd_addr_o,
  input wire       fuse_prog_req_i,
  input wire [8:0] fuse_prog_reg_i,
  input wire       fuse_prog_allow_o,
  input wire       unlock_done_o,
  input wire       config_lock_fused_i
);
  reg last_wr_r;
  // done may be registered once more after the counting write
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      last_wr_r <= 1'b0;
    else
      last_wr_r <= wr_en_i && reg_addr_i == 9'h103;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  rsvd_read_zero_a: assert property (
    rd_en_i && reg_addr_i >= 9'h0E0 && reg_addr_i <= 9'h0FF |=> rd_data_o == 8'h00)
    else $error("reserved read not zero");
  page_rsvd_clear_a: assert property (page_select_o[5:3] == 3'h0)
    else $error("page reserved bits set");
  margin_write_a: assert property (
    wr_en_i && reg_addr_i == 9'h101 |=> margin_read_o == $past(wr_data_i[0]))
    else $error("margin select not written");
  conf_lock_block_a: assert property (fuse_prog_req_i && $past(config_lock_fused_i) &&
    (fuse_prog_reg_i inside {[9'h00A:9'h036], [9'h082:9'h0CF]}) |-> !fuse_prog_allow_o)
    else $error("locked config range programmable");
  unlock_block_a: assert property (!unlock_done_o |-> !fuse_prog_allow_o)
    else $error("programming allowed while locked");
  req_single_a: assert property (fuse_rd_req_o |=> !fuse_rd_req_o)
    else $error("fuse request longer than one cycle");
  req_addr_range_a: assert property (fuse_rd_req_o |->
    (fuse_rd_addr_o inside {[8'h04:8'h17], [8'h20:8'h34]}))
    else $error("fuse request outside shadow ranges");
  unlock_cause_a: assert property ($rose(unlock_done_o) |-> last_wr_r || $past(last_wr_r))
    else $error("unlock without data write");
endmodule
bind otp_access_control otp_access_control_checker otp_access_control_checker_inst (.*);

/* File: fuse_array_model.sv */
// fuse array stand-in answering byte requests, prompt and slow in turn
`timescale 1ns/10ps
module fuse_array_model (
  input  wire       clk_i,
  input  wire       req_i,
  input  wire [7:0] addr_i,
  output reg        valid_o,
  output reg  [7:0] data_o
);
  reg [7:0] addr_r;
  reg [2:0] wait_r;
  reg       busy_r;
  reg       slow_r;
  initial begin
    valid_o = 1'b0;
    data_o = 8'h00;
    busy_r = 1'b0;
    slow_r = 1'b0;
    wait_r = 3'h0;
  end
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    data_o <= ~data_o;  // inverted every cycle between answers, so the stale byte returns every other cycle
    if (req_i) begin
      busy_r <= 1'b1;
      addr_r <= addr_i;
      wait_r <= slow_r ? 3'h5 : 3'h0;
      slow_r <= ~slow_r;
    end else if (busy_r && wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end else if (busy_r) begin
      busy_r <= 1'b0;
      valid_o <= 1'b1;
      data_o <= addr_r ^ 8'hA5;
    end
  end
endmodule

/* File: tb.sv */
// self-checking bench for the fuse access block
`timescale 1ns/10ps
module tb;
  reg ref_clk_i, nrst_i, wr_en_i, rd_en_i, emulated_read_active_i;
  reg fuse_prog_req_i, config_lock_fused_i;
  reg [8:0] reg_addr_i, fuse_prog_reg_i;
  reg [7:0] wr_data_i, got;
  reg [3:0] default_base_i;
  wire [7:0] rd_data_o, page_select_o, fuse_rd_addr_o, fuse_rd_data_i, target_chip_o;
  wire margin_read_o, fuse_rd_req_o, fuse_rd_valid_i, fuse_prog_allow_o, unlock_done_o;
  wire [3:0] if_base_addr_o;
  integer n_fail, checked, k;
  otp_access_control otp_access_control_inst (.*);
  fuse_array_model fuse_array_model_inst (.clk_i(ref_clk_i), .req_i(fuse_rd_req_o),
    .addr_i(fuse_rd_addr_o), .valid_o(fuse_rd_valid_i), .data_o(fuse_rd_data_i));
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task wr(input [8:0] a, input [7:0] d);
    begin
      @(negedge ref_clk_i);
      wr_en_i = 1'b1;
      reg_addr_i = a;
      wr_data_i = d;
      @(negedge ref_clk_i);
      wr_en_i = 1'b0;
    end
  endtask
  task peek(input [8:0] a);
    begin
      @(negedge ref_clk_i);
      rd_en_i = 1'b1;
      reg_addr_i = a;
      @(negedge ref_clk_i);
      rd_en_i = 1'b0;
      got = rd_data_o;
    end
  endtask
  task rd(input [8:0] a, input [7:0] e);
    begin
      peek(a);
      chk("rd_data_o", got, e);
    end
  endtask
  task wait_clear(input integer b);
    begin
      got = 8'hFF;
      for (k = 0; k < 300 && got[b] !== 1'b0; k = k + 1)
        peek(9'h101);
      chk("reload trigger", {7'h00, got[b]}, 8'h00);
    end
  endtask
  task t_regs;
    begin
      wr(9'h0E0, 8'h5A);
      wr(9'h0FF, 8'hA5);
      rd(9'h0E0, 8'h00);
      rd(9'h0FF, 8'h00);
      rd(9'h1F0, 8'h00);
      wr(9'h100, 8'hFF);
      rd(9'h100, 8'hC7);
      chk("page_select_o", page_select_o, 8'hC7);
      wr(9'h102, 8'hA5);
      wr(9'h103, 8'h3C);
      rd(9'h102, 8'hA5);
      rd(9'h103, 8'h3C);
      wr(9'h12B, 8'h11);
      rd(9'h12B, 8'h11);
      wr(9'h101, 8'hF1);
      rd(9'h101, 8'h01);
      chk("margin_read_o", {7'h00, margin_read_o}, 8'h01);
      wr(9'h101, 8'h00);
      chk("margin_read_o", {7'h00, margin_read_o}, 8'h00);
      emulated_read_active_i = 1'b1;
      wr(9'h101, 8'h08);
      rd(9'h101, 8'h08);
      emulated_read_active_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rd(9'h101, 8'h00);
      wr(9'h105, 8'h00);
      chk("if_base_addr_o", {4'h0, if_base_addr_o}, 8'h09);
      wr(9'h105, 8'h50);
      chk("if_base_addr_o", {4'h0, if_base_addr_o}, 8'h05);
      $display("t_regs done");
    end
  endtask
  task t_unlock;
    begin
      wr(9'h103, 8'h5A);
      wr(9'h102, 8'h5A);
      chk("target_chip_o", target_chip_o, 8'h5A);
      chk("unlock_done_o", {7'h00, unlock_done_o}, 8'h00);
      for (k = 0; k < 4; k = k + 1)
        wr(9'h103, 8'h10 + k[7:0]);
      @(negedge ref_clk_i);
      chk("unlock_done_o", {7'h00, unlock_done_o}, 8'h01);
      fuse_prog_req_i = 1'b1;
      fuse_prog_reg_i = 9'h120;
      @(negedge ref_clk_i);
      chk("fuse_prog_allow_o", {7'h00, fuse_prog_allow_o}, 8'h01);
      fuse_prog_reg_i = 9'h00A;
      config_lock_fused_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      chk("fuse_prog_allow_o", {7'h00, fuse_prog_allow_o}, 8'h00);
      $display("t_unlock done");
    end
  endtask
  task t_reload;
    begin
      wr(9'h101, 8'h04);
      wait_clear(2);
      rd(9'h104, 8'hA1);
      rd(9'h117, 8'hB2);
      rd(9'h101, 8'h60);
      fuse_prog_reg_i = 9'h104;
      @(negedge ref_clk_i);
      chk("fuse_prog_allow_o", {7'h00, fuse_prog_allow_o}, 8'h00);
      wr(9'h105, 8'h00);
      rd(9'h105, 8'hA0);
      chk("if_base_addr_o", {4'h0, if_base_addr_o}, 8'h0A);
      wr(9'h101, 8'h02);
      wait_clear(1);
      rd(9'h12B, 8'h8E);
      wr(9'h12B, 8'h11);
      rd(9'h12B, 8'h8E);
      rd(9'h101, 8'hF0);
      fuse_prog_reg_i = 9'h120;
      @(negedge ref_clk_i);
      chk("fuse_prog_allow_o", {7'h00, fuse_prog_allow_o}, 8'h00);
      fuse_prog_req_i = 1'b0;
      $display("t_reload done");
    end
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #200000;
    n_fail = n_fail + 1;
    conclude;
  end
  initial begin
    n_fail = 0;
    checked = 0;
    {nrst_i, wr_en_i, rd_en_i, emulated_read_active_i} = 4'h0;
    {fuse_prog_req_i, config_lock_fused_i} = 2'h0;
    reg_addr_i = 9'h000;
    fuse_prog_reg_i = 9'h000;
    wr_data_i = 8'h00;
    default_base_i = 4'h9;
    repeat (6) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    t_regs;
    t_unlock;
    t_reload;
    conclude;
  end
endmodule
